/* File: src/word_realigner.sv */
// per-channel word boundary realigner after the deserializer
// assumes words arrive one per low-speed tick, frequency locked to clock
//
// Operation
// - phase alignment does not fix word boundary
// - realign parallel words, one slip per channel
// - shared clock; slip from pin or logic
// - each slip rising edge shifts one bit
// - no bypass; idle slip means fixed latency
// - word width configurable to 8 or 10
// - output picks bits from two holding registers
// - past n-1 take newer word, count zero
// - new realigned word next low-speed tick
// - four-deep synchronizer buffer per channel
`timescale 1ns/1ps
module word_realigner
    import realign_pkg::*;
#(
    parameter int WIDTH = WORD_WIDTH_WIDE,
    parameter int CLOCK_DIVIDE = LOW_SPEED_DIVIDE,
    parameter int FIFO_DEPTH = STAGE_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] raw_word,
    input wire logic slip_request,
    output logic [WIDTH-1:0] aligned_word,
    output logic aligned_valid,
    input wire logic aligned_ready,
    output logic low_speed_tick,
    output logic [3:0] slip_count,
    output logic overrun
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // refused at elaboration: the window and the divider serve no other values
    if (WIDTH != WORD_WIDTH_NARROW && WIDTH != WORD_WIDTH_WIDE) begin : gen_bad_width
        $error("word_realigner width must be 8 or 10");
    end
    if (CLOCK_DIVIDE < 2 || CLOCK_DIVIDE > 255) begin : gen_bad_divide
        $error("word_realigner clock divide out of range");
    end

    typedef enum logic [2:0] {
        SLIP_IDLE = 3'h1,
        SLIP_ARMED = 3'h2,
        SLIP_WAIT_LOW = 3'h4
    } slip_state_e;

    localparam logic [3:0] LAST_COUNT = 4'(WIDTH - 1);
    localparam logic [7:0] DIVIDE_LAST = 8'(CLOCK_DIVIDE - 1);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_n;
    logic reset_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            reset_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            reset_n <= rst_meta_n;
        end
    end

    // ****************************************************************
    // low-speed enable
    // ****************************************************************
    // one clock domain only: the divided clock is a one-cycle enable
    logic [7:0] divide_count;
    logic tick;
    assign tick = (divide_count == DIVIDE_LAST);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divide_count <= '0;
        end else if (tick) begin
            divide_count <= '0;
        end else begin
            divide_count <= divide_count + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            low_speed_tick <= 1'b0;
        end else begin
            low_speed_tick <= tick;
        end
    end

    // ****************************************************************
    // synchronizer buffer
    // ****************************************************************
    // writer and reader are frequency locked, so the four-entry ring
    // needs no flags: write and read indices advance together
    logic [WIDTH-1:0] sync_ring [SYNC_DEPTH];
    logic [1:0] sync_wr;
    logic [1:0] sync_rd;
    logic [WIDTH-1:0] synced_word;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_wr <= 2'h2;
            sync_rd <= 2'h0;
            synced_word <= '0;
        end else if (tick) begin
            sync_wr <= sync_wr + 2'h1;
            sync_rd <= sync_rd + 2'h1;
            synced_word <= sync_ring[sync_rd];
        end
    end

    always_ff @(posedge clock) begin
        if (tick) begin
            sync_ring[sync_wr] <= raw_word;
        end
    end

    // ****************************************************************
    // slip edge detection
    // ****************************************************************
    // sampled on low-speed ticks; a rising edge counts only after the
    // request was low, so a long high cannot slip twice
    slip_state_e slip_state;
    slip_state_e next_slip_state;
    logic slip_event;
    always_comb begin
        next_slip_state = slip_state;
        slip_event = 1'b0;
        case (slip_state)
            SLIP_IDLE: begin
                if (tick && slip_request) begin
                    next_slip_state = SLIP_ARMED;
                    slip_event = 1'b1;
                end
            end
            SLIP_ARMED: begin
                if (tick && !slip_request) begin
                    next_slip_state = SLIP_IDLE;
                end else if (tick) begin
                    next_slip_state = SLIP_WAIT_LOW;
                end
            end
            SLIP_WAIT_LOW: begin
                if (tick && !slip_request) begin
                    next_slip_state = SLIP_IDLE;
                end
            end
            default: begin
                next_slip_state = SLIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            slip_state <= SLIP_IDLE;
        end else begin
            slip_state <= next_slip_state;
        end
    end

    // ****************************************************************
    // slip counter and holding registers
    // ****************************************************************
    // count wraps at width-1; on wrap the newer word is taken whole
    // the word boundary is set here alone, never by phase alignment
    logic [3:0] count;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= COUNT_ZERO;
        end else if (slip_event) begin
            if (count == LAST_COUNT) begin
                count <= COUNT_ZERO;
            end else begin
                count <= count + COUNT_ONE;
            end
        end
    end

    // two consecutive words, newer and older
    logic [WIDTH-1:0] hold_new;
    logic [WIDTH-1:0] hold_old;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_new <= '0;
            hold_old <= '0;
        end else if (tick) begin
            hold_new <= synced_word;
            hold_old <= hold_new;
        end
    end

    // select a width-wide window out of {old, new} starting at count;
    // count zero gives the newer word alone, so idle is a pure delay
    function automatic logic [WIDTH-1:0] pick_window(
        input logic [WIDTH-1:0] newer,
        input logic [WIDTH-1:0] older,
        input logic [3:0] shift
    );
        logic [2*WIDTH-1:0] pair;
        pair = {older, newer};
        pick_window = pair[shift +: WIDTH];
    endfunction : pick_window

    // ****************************************************************
    // output staging buffer
    // ****************************************************************
    // the realigned word goes out one tick after the slip takes effect
    // and is never bypassed; a stalled sink shows up as overrun since
    // the serial source cannot be held back
    logic [WIDTH-1:0] window;
    logic stage_ready;
    logic [WIDTH-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_take;
    assign window = pick_window(hold_new, hold_old, count);
    // output register reloads only when empty or being read, so a stall
    // never loses the word it already shows
    assign fifo_take = !aligned_valid || aligned_ready;

    word_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) stage (
        .clock(clock),
        .reset_n(reset_n),
        .in_data(window),
        .in_valid(tick),
        .in_ready(stage_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aligned_word <= '0;
            aligned_valid <= 1'b0;
            slip_count <= COUNT_ZERO;
            overrun <= 1'b0;
        end else begin
            if (fifo_take) begin
                aligned_word <= fifo_data;
                aligned_valid <= fifo_valid;
            end
            slip_count <= count;
            if (tick && !stage_ready) begin
                overrun <= 1'b1; // sticky until reset: a word was dropped
            end
        end
    end
endmodule : word_realigner

/* File: src/realign_pkg.sv */
// constants shared by the word realigner and its output staging buffer
// assumes one 100 MHz clock; the divided low-speed rate is an enable pulse
package realign_pkg;
    // ****************************************************************
    // word widths and buffer shape
    // ****************************************************************
    localparam int WORD_WIDTH_NARROW = 8;
    localparam int WORD_WIDTH_WIDE = 10;
    localparam int SYNC_DEPTH = 4;
    localparam int STAGE_DEPTH = 32;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int LOW_SPEED_DIVIDE = 4;
    // the slip agent holds the request high this many low-speed ticks; one high tick already slips
    localparam int SLIP_HIGH_TICKS = 2;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_ONE = 4'h1;
endpackage : realign_pkg

/* File: src/word_fifo.sv */
// small FIFO with valid/ready on both sides and registered read data
// assumes a single clock and synchronous use on both sides
`timescale 1ns/1ps
module word_fifo
    import realign_pkg::*;
#(
    parameter int WIDTH = WORD_WIDTH_WIDE,
    parameter int DEPTH = STAGE_DEPTH
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // refused at elaboration: pointer wrap needs a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gen_bad_depth
        $error("word_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] fill;
    logic push;
    logic pop;

    // ****************************************************************
    // pointers and flags
    // ****************************************************************
    // out register holds the head word, so the array holds the rest
    assign fill = wr_ptr - rd_ptr;
    assign in_ready = (fill != (AW + 1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = (fill != '0) && (!out_valid || out_ready);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // read side: head word lives in a register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr[AW-1:0]];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule : word_fifo

/* File: tb/word_realigner_monitor.sv */
// port checker for the word realigner
// assumes it is bound to every word_realigner instance
`timescale 1ns/1ps
module word_realigner_monitor #(
    parameter int WIDTH = 10,
    parameter int CLOCK_DIVIDE = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] raw_word,
    input wire logic slip_request,
    input wire logic [WIDTH-1:0] aligned_word,
    input wire logic aligned_valid,
    input wire logic aligned_ready,
    input wire logic low_speed_tick,
    input wire logic [3:0] slip_count,
    input wire logic overrun
);
    // ****
    // cycles since the last tick
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [7:0] gap;
    logic seen;
    // first tick after reset has no reference, so it is skipped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else if (low_speed_tick) begin
            gap <= 8'h00;
            seen <= 1'b1;
        end else begin
            gap <= gap + 8'h01;
        end
    end
    AST_TICK_SPACING:
    assert property (low_speed_tick && seen |-> gap == 8'(CLOCK_DIVIDE - 1)) else $error("tick gap");
    AST_TICK_PULSE:
    assert property (low_speed_tick |=> !low_speed_tick) else $error("tick too long");
    AST_COUNT_RANGE:
    assert property (slip_count < 4'(WIDTH)) else $error("count out of range");
    AST_COUNT_STEP:
    assert property (slip_count != $past(slip_count) |-> slip_count ==
        (($past(slip_count) == 4'(WIDTH - 1)) ? 4'h0 : $past(slip_count) + 4'h1))
        else $error("count step");
    AST_ONE_SLIP:
    assert property ($changed(slip_count) |=> $stable(slip_count) [*3]) else $error("double slip");
    AST_SLIP_CAUSE:
    assert property ($changed(slip_count) |-> $past(slip_request, 2) || $past(slip_request, 3))
        else $error("slip without request");
    AST_OVERRUN_STICKY:
    assert property (overrun |=> overrun) else $error("overrun cleared");
    AST_HOLD_STALLED:
    assert property (aligned_valid && !aligned_ready |=> aligned_valid && $stable(aligned_word))
        else $error("stalled word changed");
endmodule : word_realigner_monitor
bind word_realigner word_realigner_monitor #(.WIDTH(WIDTH), .CLOCK_DIVIDE(CLOCK_DIVIDE)) u_monitor (
    .clock, .rst_n, .raw_word, .slip_request, .aligned_word, .aligned_valid,
    .aligned_ready, .low_speed_tick, .slip_count, .overrun);

/* File: tb/slip_agent.sv */
// user-side model that pulses the slip request and hunts a pattern
// assumes tick is the realigner's low-speed tick output
`timescale 1ns/1ps
module slip_agent #(
    parameter int WIDTH = 10
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic go,
    input wire logic hunt,
    input wire logic [WIDTH-1:0] word,
    input wire logic [WIDTH-1:0] pattern,
    output logic slip_request,
    output logic busy
);
    // ****
    // pulse sequencer
    // ****
    logic [WIDTH-1:0] word_q;
    logic [3:0] phase;
    assign busy = phase != 4'h0;
    // words registered before the compare
    always_ff @(posedge clock) begin
        word_q <= word;
    end
    // long low gap also lets the pipeline settle before the next compare
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 4'h0;
        end else if (tick && busy) begin
            phase <= (phase == 4'he) ? 4'h0 : phase + 4'h1;
        end else if (tick && (go || (hunt && word_q != pattern))) begin
            phase <= 4'h1;
        end
    end
    // output register in front of the realigner
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slip_request <= 1'b0;
        end else begin
            slip_request <= phase == 4'h1 || phase == 4'h2;
        end
    end
endmodule : slip_agent

/* File: tb/tb_word_realigner.sv */
// self-checking bench: random words, one slip per phase, hunt, overflow
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module tb_word_realigner;
    import realign_pkg::*;
    localparam int W = WORD_WIDTH_WIDE;
    localparam logic [W-1:0] CONST_WORD = 10'h013;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [W-1:0] raw_word = 10'h000;
    logic [W-1:0] pattern = 10'h000;
    logic aligned_ready = 1'b1;
    logic go = 1'b0;
    logic hunt = 1'b0;
    logic use_const = 1'b0;
    logic collect = 1'b0;
    logic [W-1:0] aligned_word;
    logic aligned_valid, low_speed_tick, slip_request, busy, overrun;
    logic [3:0] slip_count;
    logic [W-1:0] hist[$];
    logic [W-1:0] outq[$];
    localparam int N = WORD_WIDTH_NARROW;
    logic [N-1:0] narrow_word;
    logic narrow_valid, narrow_overrun;
    logic [3:0] narrow_count;
    logic [N-1:0] outq8[$];
    int slips = 0;
    int seed = 32'h7d9b;
    int mismatches = 0;
    int compares = 0;
    // ****
    // design, partner, stimulus
    // ****
    word_realigner #(.WIDTH(W), .CLOCK_DIVIDE(4), .FIFO_DEPTH(32)) u_dut (.clock, .rst_n,
        .raw_word, .slip_request, .aligned_word, .aligned_valid, .aligned_ready,
        .low_speed_tick, .slip_count, .overrun);
    slip_agent #(.WIDTH(W)) u_agent (.clock, .rst_n, .tick(low_speed_tick), .go, .hunt,
        .word(aligned_word), .pattern, .slip_request, .busy);
    // narrow copy sees the same words and slips, so the 8-bit mode is exercised too
    word_realigner #(.WIDTH(N), .CLOCK_DIVIDE(4), .FIFO_DEPTH(32)) u_dut_narrow (
        .clock, .rst_n,
        .raw_word(raw_word[N-1:0]), .slip_request,
        .aligned_word(narrow_word), .aligned_valid(narrow_valid), .aligned_ready,
        .low_speed_tick(), .slip_count(narrow_count), .overrun(narrow_overrun));
    always #5 clock = ~clock;
    // one word per tick, remembered in order; outputs read 1 ns after the edge
    always @(posedge clock) begin
        #1;
        if (collect && aligned_valid) outq.push_back(aligned_word);
        if (collect && narrow_valid) outq8.push_back(narrow_word);
        if (low_speed_tick) begin
            raw_word = use_const ? CONST_WORD : W'($random(seed));
            hist.push_back(raw_word);
        end
    end
    function automatic logic [W-1:0] shifted(input logic [W-1:0] nw, od, input int k);
        shifted = W'({od, nw} >> k);
    endfunction : shifted
    function automatic logic [N-1:0] shifted8(input logic [N-1:0] nw, od, input int k);
        shifted8 = N'({od, nw} >> k);
    endfunction : shifted8
    task automatic check(input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic ticks(input int n);
        repeat (n) @(posedge low_speed_tick);
        #1;
    endtask : ticks
    task automatic slip();
        go = 1'b1;
        wait (busy);
        #1 go = 1'b0;
        wait (!busy);
        slips++;
    endtask : slip
    // find where the output stream lines up with history, then walk it
    task automatic check_phase(input int k);
        int j;
        ticks(10);
        outq = {};
        outq8 = {};
        collect = 1'b1;
        ticks(8);
        collect = 1'b0;
        j = -1;
        check(slip_count, k[15:0]);
        for (int i = 1; i + 3 < hist.size(); i++)
            if (j < 0 && outq[0] === shifted(hist[i], hist[i-1], k)
                && outq[1] === shifted(hist[i+1], hist[i], k)) j = i;
        check(j >= 0, 1'b1);
        for (int m = 0; j >= 0 && m < outq.size(); m++)
            check(outq[m], shifted(hist[j+m], hist[j+m-1], k));
        check(narrow_count, 4'(slips % N));
        check(outq8.size() > 0, 1'b1);
        for (int m = 0; j >= 0 && m < outq8.size(); m++)
            check(outq8[m], shifted8(hist[j+m][N-1:0], hist[j+m-1][N-1:0], slips % N));
    endtask : check_phase
    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    // ****
    // main sequence
    // ****
    initial begin
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        ticks(4);
        check_phase(0);
        for (int k = 1; k <= W; k++) begin
            slip();
            check_phase(k % W);
        end
        use_const = 1'b1;
        pattern = shifted(CONST_WORD, CONST_WORD, 3);
        ticks(10);
        hunt = 1'b1;
        ticks(4);
        for (int n = 0; n < 400 && (busy || aligned_word !== pattern); n++) ticks(1);
        hunt = 1'b0;
        check(slip_count, 4'h3);
        check(aligned_word, pattern);
        check(narrow_count, 4'((slips + 3) % N));
        use_const = 1'b0;
        check(overrun, 1'b0);
        check(narrow_overrun, 1'b0);
        aligned_ready = 1'b0;
        ticks(40);
        check(overrun, 1'b1);
        check(narrow_overrun, 1'b1);
        aligned_ready = 1'b1;
        ticks(12);
        check(overrun, 1'b1);
        rst_n = 1'b0;
        #20;
        check({aligned_valid, overrun, slip_count}, 6'h00);
        rst_n = 1'b1;
        ticks(2);
        check({overrun, slip_count, narrow_count}, 9'h000);
        report_and_stop();
    end
endmodule : tb_word_realigner
